// ==== hdl/uda_data_path.sv ====
// serial port data path with shared data / divisor-low register
`timescale 1ns/1ns
`default_nettype none
module uda_data_path #(
  parameter int DEPTH = uda_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [31:0] reg_addr,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb,
  output logic [15:0] reg_rd_data,
  output logic irq,
  input wire logic serial_in,
  output logic serial_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic rx_s1;
    logic rx_s2;
    logic [7:0] line_ctrl;
    logic fifo_en;
    logic [15:0] divisor;
    logic [DEPTH-1:0][7:0] rx_mem;
    logic [AW-1:0] rx_wp;
    logic [AW-1:0] rx_rp;
    logic [AW:0] rx_cnt;
    logic [DEPTH-1:0][7:0] tx_mem;
    logic [AW-1:0] tx_wp;
    logic [AW-1:0] tx_rp;
    logic [AW:0] tx_cnt;
    logic overrun;
    logic [uda_pkg::IRQ_BITS-1:0] irq_stat;
    logic [uda_pkg::IRQ_BITS-1:0] irq_mask;
    logic [15:0] baud_cnt;
    logic tick;
    uda_pkg::uda_ser_e tx_state;
    logic [7:0] tx_sh;
    logic [3:0] tx_tick;
    logic [2:0] tx_bit;
    logic tx_line;
    uda_pkg::uda_ser_e rx_state;
    logic [7:0] rx_sh;
    logic [3:0] rx_tick;
    logic [2:0] rx_bit;
    logic [15:0] rd_data;
    logic irq;
  } uda_state_s;

  uda_state_s s_ff;
  uda_state_s nxt_s;
  logic divisor_access_bit;
  logic data_rd;
  logic data_wr;
  logic rx_push;
  logic rx_pop;
  logic tx_push;
  logic tx_pop;
  logic rx_full;
  logic tx_full;
  logic [7:0] rx_new;
  logic [7:0] rx_head;
  logic [uda_pkg::IRQ_BITS-1:0] irq_set;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = p + AW'(1);
  endfunction : ptr_inc

  function automatic logic [AW:0] cnt_step(input logic [AW:0] c, input logic up, input logic dn);
    cnt_step = c + (AW + 1)'(up) - (AW + 1)'(dn);
  endfunction : cnt_step

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    nxt_s = s_ff;
    divisor_access_bit = s_ff.line_ctrl[uda_pkg::DIV_ACCESS_BIT];
    rx_head = s_ff.rx_mem[s_ff.rx_rp];
    data_rd = reg_rd_stb && reg_addr == uda_pkg::ADDR_DATA && !divisor_access_bit;
    data_wr = reg_wr_stb && reg_addr == uda_pkg::ADDR_DATA && !divisor_access_bit;
    rx_push = 1'b0;
    tx_pop = 1'b0;
    rx_new = {s_ff.rx_s2, s_ff.rx_sh[7:1]};
    irq_set = '0;
    nxt_s.rx_s1 = serial_in;
    nxt_s.rx_s2 = s_ff.rx_s1;

    // baud tick: period of divisor cycles, sixteen ticks per bit
    nxt_s.tick = 1'b0;
    if (s_ff.divisor == 16'h0000) begin
      nxt_s.baud_cnt = 16'h0000;
    end else if (s_ff.baud_cnt == 16'h0000) begin
      nxt_s.baud_cnt = s_ff.divisor - 16'h0001;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.baud_cnt = s_ff.baud_cnt - 16'h0001;
    end

    // ********************************************************************
    // receiver
    // ********************************************************************
    unique case (s_ff.rx_state)
      uda_pkg::SER_IDLE: begin
        if (!s_ff.rx_s2 && s_ff.divisor != 16'h0000) begin
          nxt_s.rx_state = uda_pkg::SER_START;
          nxt_s.rx_tick = 4'h0;
        end
      end
      uda_pkg::SER_START: begin
        if (s_ff.tick) begin
          nxt_s.rx_tick = s_ff.rx_tick + 4'h1;
          if (s_ff.rx_tick == uda_pkg::TICK_MID) begin
            // glitch shorter than half a bit is not a start
            nxt_s.rx_state = s_ff.rx_s2 ? uda_pkg::SER_IDLE : uda_pkg::SER_DATA;
            nxt_s.rx_tick = 4'h0;
            nxt_s.rx_bit = 3'h0;
          end
        end
      end
      uda_pkg::SER_DATA: begin
        if (s_ff.tick) begin
          nxt_s.rx_tick = s_ff.rx_tick + 4'h1;
          if (s_ff.rx_tick == uda_pkg::TICK_LAST) begin
            nxt_s.rx_sh = rx_new;
            nxt_s.rx_bit = s_ff.rx_bit + 3'h1;
            if (s_ff.rx_bit == uda_pkg::BIT_LAST) begin
              nxt_s.rx_state = uda_pkg::SER_STOP;
            end
          end
        end
      end
      uda_pkg::SER_STOP: begin
        if (s_ff.tick) begin
          nxt_s.rx_tick = s_ff.rx_tick + 4'h1;
          if (s_ff.rx_tick == uda_pkg::TICK_LAST) begin
            // framing errors are dropped here; line status has no framing error bit
            rx_push = s_ff.rx_s2;
            nxt_s.rx_state = uda_pkg::SER_IDLE;
          end
        end
      end
    endcase

    // ********************************************************************
    // receive buffer / FIFO
    // ********************************************************************
    rx_pop = data_rd && s_ff.rx_cnt != '0;
    rx_full = s_ff.fifo_en ? s_ff.rx_cnt == FULL_CNT : s_ff.rx_cnt != '0;
    if (rx_push && rx_full && !rx_pop) begin
      nxt_s.overrun = 1'b1;
      irq_set[uda_pkg::IRQ_OVR_BIT] = 1'b1;
      if (!s_ff.fifo_en) begin
        nxt_s.rx_mem[s_ff.rx_rp] = s_ff.rx_sh;
      end
      // fifo mode: keep stored entries, lose the newcomer
    end else if (rx_push) begin
      nxt_s.rx_mem[s_ff.rx_wp] = s_ff.rx_sh;
      nxt_s.rx_wp = ptr_inc(s_ff.rx_wp);
    end
    if (rx_push) begin
      irq_set[uda_pkg::IRQ_RX_BIT] = 1'b1;
    end
    if (rx_pop) begin
      nxt_s.rx_rp = ptr_inc(s_ff.rx_rp);
    end
    nxt_s.rx_cnt = cnt_step(s_ff.rx_cnt, rx_push && !(rx_full && !rx_pop), rx_pop);

    // ********************************************************************
    // transmitter
    // ********************************************************************
    unique case (s_ff.tx_state)
      uda_pkg::SER_IDLE: begin
        // start on a tick so every bit, start included, lasts exactly sixteen ticks
        if (s_ff.tx_cnt != '0 && s_ff.divisor != 16'h0000 && s_ff.tick) begin
          tx_pop = 1'b1;
          nxt_s.tx_sh = s_ff.tx_mem[s_ff.tx_rp];
          nxt_s.tx_line = 1'b0;
          nxt_s.tx_tick = 4'h0;
          nxt_s.tx_state = uda_pkg::SER_START;
        end
      end
      uda_pkg::SER_START: begin
        if (s_ff.tick) begin
          nxt_s.tx_tick = s_ff.tx_tick + 4'h1;
          if (s_ff.tx_tick == uda_pkg::TICK_LAST) begin
            nxt_s.tx_line = s_ff.tx_sh[0];
            nxt_s.tx_bit = 3'h0;
            nxt_s.tx_state = uda_pkg::SER_DATA;
          end
        end
      end
      uda_pkg::SER_DATA: begin
        if (s_ff.tick) begin
          nxt_s.tx_tick = s_ff.tx_tick + 4'h1;
          if (s_ff.tx_tick == uda_pkg::TICK_LAST) begin
            nxt_s.tx_sh = {1'b0, s_ff.tx_sh[7:1]};
            nxt_s.tx_line = s_ff.tx_sh[1];
            nxt_s.tx_bit = s_ff.tx_bit + 3'h1;
            if (s_ff.tx_bit == uda_pkg::BIT_LAST) begin
              nxt_s.tx_line = 1'b1;
              nxt_s.tx_state = uda_pkg::SER_STOP;
            end
          end
        end
      end
      uda_pkg::SER_STOP: begin
        if (s_ff.tick) begin
          nxt_s.tx_tick = s_ff.tx_tick + 4'h1;
          if (s_ff.tx_tick == uda_pkg::TICK_LAST) begin
            nxt_s.tx_state = uda_pkg::SER_IDLE;
          end
        end
      end
    endcase

    // ********************************************************************
    // transmit holding / FIFO
    // ********************************************************************
    tx_push = data_wr;
    tx_full = s_ff.fifo_en ? s_ff.tx_cnt == FULL_CNT : s_ff.tx_cnt != '0;
    if (tx_push && tx_full && !tx_pop) begin
      if (!s_ff.fifo_en) begin
        nxt_s.tx_mem[s_ff.tx_rp] = reg_wr_data[7:0];
      end
      // fifo mode: write while full is lost
    end else if (tx_push) begin
      nxt_s.tx_mem[s_ff.tx_wp] = reg_wr_data[7:0];
      nxt_s.tx_wp = ptr_inc(s_ff.tx_wp);
    end
    if (tx_pop) begin
      nxt_s.tx_rp = ptr_inc(s_ff.tx_rp);
      irq_set[uda_pkg::IRQ_TX_BIT] = s_ff.tx_cnt == (AW + 1)'(1) && !tx_push;
    end
    nxt_s.tx_cnt = cnt_step(s_ff.tx_cnt, tx_push && !(tx_full && !tx_pop), tx_pop);

    // ********************************************************************
    // register writes
    // ********************************************************************
    if (reg_wr_stb) begin
      unique case (reg_addr)
        uda_pkg::ADDR_DATA: begin
          if (divisor_access_bit) begin
            nxt_s.divisor[7:0] = reg_wr_data[7:0];
          end
        end
        uda_pkg::ADDR_DIV_HIGH: begin
          if (divisor_access_bit) begin
            nxt_s.divisor[15:8] = reg_wr_data[7:0];
          end
        end
        uda_pkg::ADDR_FIFO_CTRL: begin
          nxt_s.fifo_en = reg_wr_data[uda_pkg::FIFO_EN_BIT];
          // mode change flushes both buffers; mixing modes would corrupt counts
          if (reg_wr_data[uda_pkg::FIFO_EN_BIT] != s_ff.fifo_en) begin
            nxt_s.rx_cnt = '0;
            nxt_s.rx_wp = '0;
            nxt_s.rx_rp = '0;
            nxt_s.tx_cnt = '0;
            nxt_s.tx_wp = '0;
            nxt_s.tx_rp = '0;
          end
        end
        uda_pkg::ADDR_LINE_CTRL: nxt_s.line_ctrl = reg_wr_data[7:0];
        uda_pkg::ADDR_IRQ_MASK: nxt_s.irq_mask = reg_wr_data[uda_pkg::IRQ_BITS-1:0];
        default: ;
      endcase
    end

    // ********************************************************************
    // register reads, data one cycle later; read clears lose to new sets
    // ********************************************************************
    nxt_s.rd_data = 16'h0000;
    if (reg_rd_stb) begin
      unique case (reg_addr)
        uda_pkg::ADDR_DATA: nxt_s.rd_data = {8'h00, divisor_access_bit ? s_ff.divisor[7:0] : rx_head};
        uda_pkg::ADDR_DIV_HIGH: nxt_s.rd_data = {8'h00, divisor_access_bit ? s_ff.divisor[15:8] : 8'h00};
        uda_pkg::ADDR_FIFO_CTRL: nxt_s.rd_data = {15'h0000, s_ff.fifo_en};
        uda_pkg::ADDR_LINE_CTRL: nxt_s.rd_data = {8'h00, s_ff.line_ctrl};
        uda_pkg::ADDR_LINE_STATUS: begin
          nxt_s.rd_data[uda_pkg::LS_DATA_READY_BIT] = s_ff.rx_cnt != '0;
          nxt_s.rd_data[uda_pkg::LS_OVERRUN_BIT] = s_ff.overrun;
          nxt_s.rd_data[uda_pkg::LS_TX_EMPTY_BIT] = s_ff.tx_cnt == '0;
          nxt_s.rd_data[uda_pkg::LS_TX_IDLE_BIT] = s_ff.tx_cnt == '0 && s_ff.tx_state == uda_pkg::SER_IDLE;
          nxt_s.overrun = irq_set[uda_pkg::IRQ_OVR_BIT];
        end
        uda_pkg::ADDR_IRQ_STATUS: begin
          nxt_s.rd_data = {13'h0000, s_ff.irq_stat};
          nxt_s.irq_stat = '0;
        end
        uda_pkg::ADDR_IRQ_MASK: nxt_s.rd_data = {13'h0000, s_ff.irq_mask};
        default: ;
      endcase
    end
    nxt_s.irq_stat = nxt_s.irq_stat | irq_set;
    nxt_s.irq = |(nxt_s.irq_stat & s_ff.irq_mask);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.rx_s1 <= 1'b1;
      s_ff.rx_s2 <= 1'b1;
      s_ff.tx_line <= 1'b1;
      s_ff.divisor <= uda_pkg::DIVISOR_RESET;
      s_ff.line_ctrl <= uda_pkg::LINE_CTRL_RESET;
      s_ff.irq_mask <= uda_pkg::IRQ_MASK_RESET;
      s_ff.tx_state <= uda_pkg::SER_IDLE;
      s_ff.rx_state <= uda_pkg::SER_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign reg_rd_data = s_ff.rd_data;
  assign irq = s_ff.irq;
  assign serial_out = s_ff.tx_line;

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_zero_div_still: assert property (s_ff.divisor == 16'h0000 |=> !s_ff.tick)
    else $error("baud tick seen with zero divisor");
  a_rx_head_read: assert property (data_rd |=> reg_rd_data == {8'h00, $past(rx_head)})
    else $error("data read did not return receive head");
  a_rx_fifo_pop: assert property (data_rd && s_ff.fifo_en && s_ff.rx_cnt != '0 && !rx_push |=> s_ff.rx_cnt == $past(s_ff.rx_cnt) - (AW + 1)'(1))
    else $error("fifo read did not consume an entry");
  a_rx_full_drop: assert property (s_ff.fifo_en && rx_push && s_ff.rx_cnt == FULL_CNT && !rx_pop |=> s_ff.rx_cnt == FULL_CNT && s_ff.overrun && $stable(s_ff.rx_mem))
    else $error("full receive fifo not preserved on overrun");
  a_rx_overwrite: assert property (!s_ff.fifo_en && rx_push && s_ff.rx_cnt != '0 && !rx_pop |=> s_ff.overrun && s_ff.rx_cnt == (AW + 1)'(1) && rx_head == $past(s_ff.rx_sh))
    else $error("unread byte not replaced with overrun");
  a_thr_overwrite: assert property (!s_ff.fifo_en && data_wr && s_ff.tx_cnt != '0 && !tx_pop |=> s_ff.tx_cnt == (AW + 1)'(1) && s_ff.tx_mem[s_ff.tx_rp] == $past(reg_wr_data[7:0]))
    else $error("held transmit byte not overwritten");
  a_tx_full_drop: assert property (s_ff.fifo_en && data_wr && s_ff.tx_cnt == FULL_CNT && !tx_pop |=> s_ff.tx_cnt == FULL_CNT && $stable(s_ff.tx_mem))
    else $error("write to full transmit fifo not dropped");
  a_dll_write: assert property (reg_wr_stb && reg_addr == uda_pkg::ADDR_DATA && divisor_access_bit |=> s_ff.divisor[7:0] == $past(reg_wr_data[7:0]) && s_ff.tx_cnt <= $past(s_ff.tx_cnt))
    else $error("divisor low write misrouted");
  a_dlh_guard: assert property (reg_wr_stb && reg_addr == uda_pkg::ADDR_DIV_HIGH && !divisor_access_bit |=> $stable(s_ff.divisor[15:8]))
    else $error("divisor high changed without access bit");
  a_tick_period: assert property (s_ff.tick && s_ff.divisor == 16'h0003 && $stable(s_ff.divisor) |=> !s_ff.tick ##1 !s_ff.tick ##1 s_ff.tick)
    else $error("baud tick period differs from divisor");
endmodule : uda_data_path
`default_nettype wire

// ==== hdl/uda_pkg.sv ====
// constants for the serial data / divisor-low register path
package uda_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_DATA = 32'h5000_1000;
  localparam logic [31:0] ADDR_DIV_HIGH = 32'h5000_1004;
  localparam logic [31:0] ADDR_FIFO_CTRL = 32'h5000_1008;
  localparam logic [31:0] ADDR_LINE_CTRL = 32'h5000_100c;
  localparam logic [31:0] ADDR_LINE_STATUS = 32'h5000_1014;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h5000_10e0;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h5000_10e4;
  // field positions
  localparam int DIV_ACCESS_BIT = 7;
  localparam int FIFO_EN_BIT = 0;
  localparam int LS_DATA_READY_BIT = 0;
  localparam int LS_OVERRUN_BIT = 1;
  localparam int LS_TX_EMPTY_BIT = 5;
  localparam int LS_TX_IDLE_BIT = 6;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_OVR_BIT = 1;
  localparam int IRQ_TX_BIT = 2;
  localparam int IRQ_BITS = 3;
  // reset values
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;
  localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  // sizes and timing
  localparam int FIFO_DEPTH = 16;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_START = 2'b01,
    SER_DATA = 2'b10,
    SER_STOP = 2'b11
  } uda_ser_e;
endpackage : uda_pkg

// ==== test/uda_serial_peer.sv ====
// behavioural far-end serial transceiver facing the data path
`timescale 1ns/1ns
`default_nettype none
module uda_serial_peer (
  input wire logic sys_clk,
  input wire logic [15:0] bit_cycles,
  input wire logic line_from_dut,
  output logic line_to_dut
);
  logic [7:0] got_q[$];
  initial line_to_dut = 1'b1;
  // ************
  // transmit side
  // ************
  // start, 8 data lsb first, stop; the line rests high between frames
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_to_dut <= frame[i];
      repeat (bit_cycles) @(posedge sys_clk);
    end
  endtask : send_byte
  // ************
  // receive side
  // ************
  // sampled mid-bit; a frame whose stop bit is low is dropped, as a real receiver would
  initial begin : rx_loop
    logic [7:0] b;
    forever begin
      @(negedge line_from_dut);
      repeat (bit_cycles / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cycles) @(posedge sys_clk);
        b[i] = line_from_dut;
      end
      repeat (bit_cycles) @(posedge sys_clk);
      if (line_from_dut === 1'b1) begin
        got_q.push_back(b);
      end
    end
  end
endmodule : uda_serial_peer
`default_nettype wire

// ==== test/uda_data_path_test.sv ====
// self-checking bench for the serial data / divisor-low register path
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module uda_data_path_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] reg_addr = 32'h0000_0000;
  logic [15:0] reg_wr_data = 16'h0000;
  logic reg_wr_stb = 1'b0;
  logic reg_rd_stb = 1'b0;
  logic [15:0] reg_rd_data;
  logic irq;
  logic serial_in;
  logic serial_out;
  logic [15:0] bit_cycles = 16'h0010;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  uda_data_path dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rd_data(reg_rd_data), .irq(irq),
    .serial_in(serial_in), .serial_out(serial_out));
  uda_serial_peer peer (.sys_clk(sys_clk), .bit_cycles(bit_cycles), .line_from_dut(serial_out),
    .line_to_dut(serial_in));
  initial forever #25 sys_clk = ~sys_clk;
  // ************
  // bus and helpers
  // ************
  // one idle cycle after each write so a strobe is never assigned twice in one step
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_stb <= 1'b1;
    @(posedge sys_clk);
    reg_wr_stb <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd_stb <= 1'b1;
    @(posedge sys_clk);
    reg_rd_stb <= 1'b0;
    @(negedge sys_clk);
    d = reg_rd_data;
    @(posedge sys_clk);
  endtask : rd
  task automatic set_div(input logic [7:0] lo);
    bit_cycles <= 16'(lo) * 16'h0010;
    wr(uda_pkg::ADDR_LINE_CTRL, 16'h0080);
    wr(uda_pkg::ADDR_DATA, {8'h00, lo});
    wr(uda_pkg::ADDR_DIV_HIGH, 16'h0000);
    wr(uda_pkg::ADDR_LINE_CTRL, 16'h0000);
    repeat (8 * 16 * lo) @(posedge sys_clk);
  endtask : set_div
  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (peer.got_q.size() < n && k < 20000) begin
      @(posedge sys_clk);
      k++;
    end
  endtask : wait_rx
  task automatic start_len(output int n);
    int k;
    n = 0;
    k = 0;
    while (serial_out !== 1'b0 && k < 2000) begin
      @(negedge sys_clk);
      k++;
    end
    while (serial_out === 1'b0 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
  endtask : start_len
  // irq is registered, so it is judged two settled cycles later
  task automatic irq_is(input logic e);
    repeat (2) @(negedge sys_clk);
    `CHK(irq, e)
    @(posedge sys_clk);
  endtask : irq_is
  // ************
  // scenarios
  // ************
  task automatic t_regs();
    logic [15:0] d;
    rd(uda_pkg::ADDR_DATA, d);
    `CHK(d, 16'h0000)
    wr(uda_pkg::ADDR_LINE_CTRL, 16'h0080);
    rd(uda_pkg::ADDR_DATA, d);
    `CHK(d, uda_pkg::DIVISOR_RESET)
    wr(uda_pkg::ADDR_DATA, 16'hab5a);
    rd(uda_pkg::ADDR_DATA, d);
    `CHK(d, 16'h005a)
    wr(uda_pkg::ADDR_DIV_HIGH, 16'h0012);
    rd(uda_pkg::ADDR_DIV_HIGH, d);
    `CHK(d, 16'h0012)
    wr(uda_pkg::ADDR_LINE_CTRL, 16'h0000);
    rd(uda_pkg::ADDR_DIV_HIGH, d);
    `CHK(d, 16'h0000)
    rd(uda_pkg::ADDR_DATA, d);
    `CHK(d, 16'h0000)
    rd(32'h5000_1ffc, d);
    `CHK(d, 16'h0000)
    set_div(8'h00);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_tx_fifo();
    int lows;
    lows = 0;
    wr(uda_pkg::ADDR_FIFO_CTRL, 16'h0001);
    for (int i = 0; i < 17; i++) begin
      wr(uda_pkg::ADDR_DATA, 16'h0040 + 16'(i));
    end
    repeat (300) begin
      @(negedge sys_clk);
      if (serial_out !== 1'b1) lows++;
    end
    @(posedge sys_clk);
    `CHK(lows, 0)
    set_div(8'h01);
    wait_rx(16);
    repeat (400) @(posedge sys_clk);
    `CHK(peer.got_q.size(), 16)
    for (int i = 0; i < 16; i++) begin
      `CHK(peer.got_q[i], 8'h40 + 8'(i))
    end
    peer.got_q.delete();
    wr(uda_pkg::ADDR_FIFO_CTRL, 16'h0000);
    $display("t_tx_fifo done");
  endtask : t_tx_fifo
  task automatic t_tx_irq();
    logic [15:0] d;
    int n;
    set_div(8'h03);
    wr(uda_pkg::ADDR_IRQ_MASK, 16'h0000);
    rd(uda_pkg::ADDR_IRQ_STATUS, d);
    rd(uda_pkg::ADDR_LINE_STATUS, d);
    `CHK(d[uda_pkg::LS_TX_EMPTY_BIT], 1'b1)
    wr(uda_pkg::ADDR_DATA, 16'h0055);
    start_len(n);
    `CHK(n, 48)
    wr(uda_pkg::ADDR_DATA, 16'h0011);
    wr(uda_pkg::ADDR_DATA, 16'h00a6);
    rd(uda_pkg::ADDR_LINE_STATUS, d);
    `CHK(d[uda_pkg::LS_TX_EMPTY_BIT], 1'b0)
    wait_rx(2);
    `CHK(peer.got_q.size(), 2)
    `CHK(peer.got_q[0], 8'h55)
    `CHK(peer.got_q[1], 8'ha6)
    peer.got_q.delete();
    irq_is(1'b0);
    wr(uda_pkg::ADDR_IRQ_MASK, 16'h0004);
    irq_is(1'b1);
    rd(uda_pkg::ADDR_IRQ_STATUS, d);
    `CHK(d, 16'h0004)
    irq_is(1'b0);
    $display("t_tx_irq done");
  endtask : t_tx_irq
  task automatic t_rx_single();
    logic [15:0] d;
    wr(uda_pkg::ADDR_IRQ_MASK, 16'h0003);
    peer.send_byte(8'h3c);
    repeat (bit_cycles) @(posedge sys_clk);
    irq_is(1'b1);
    peer.send_byte(8'hc5);
    repeat (bit_cycles) @(posedge sys_clk);
    rd(uda_pkg::ADDR_LINE_STATUS, d);
    `CHK(d[1:0], 2'b11)
    rd(uda_pkg::ADDR_DATA, d);
    `CHK(d, 16'h00c5)
    rd(uda_pkg::ADDR_IRQ_STATUS, d);
    `CHK(d, 16'h0003)
    irq_is(1'b0);
    rd(uda_pkg::ADDR_LINE_STATUS, d);
    `CHK(d[uda_pkg::LS_DATA_READY_BIT], 1'b0)
    $display("t_rx_single done");
  endtask : t_rx_single
  task automatic t_rx_fifo();
    logic [15:0] d;
    wr(uda_pkg::ADDR_FIFO_CTRL, 16'h0001);
    for (int i = 0; i < 17; i++) begin
      peer.send_byte(8'h80 + 8'(i));
    end
    repeat (bit_cycles) @(posedge sys_clk);
    rd(uda_pkg::ADDR_LINE_STATUS, d);
    `CHK(d[1:0], 2'b11)
    for (int i = 0; i < 16; i++) begin
      rd(uda_pkg::ADDR_DATA, d);
      `CHK(d, 16'h0080 + 16'(i))
    end
    rd(uda_pkg::ADDR_LINE_STATUS, d);
    `CHK(d[1:0], 2'b00)
    $display("t_rx_fifo done");
  endtask : t_rx_fifo
  // ************
  // run control
  // ************
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  // about three times the expected length of the whole run
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_tx_fifo();
    t_tx_irq();
    t_rx_single();
    t_rx_fifo();
    results();
  end
endmodule : uda_data_path_test
`default_nettype wire
